// [pkg/contact_mon_pkg.sv]
// Shared constants for the contact monitor control logic.
// Assumes a 100 MHz system clock; all counts derive from it.
package contact_mon_pkg;

  // Clock rate
  localparam int CLK_MHZ = 100;

  // Timing figures and derived cycle counts
  localparam int POLL_US = 250;
  localparam int POLL_CYC = POLL_US * CLK_MHZ;
  localparam int SCAN_MIN_MS = 2;
  localparam int SCAN_MIN_CYC = SCAN_MIN_MS * 1000 * CLK_MHZ;
  localparam int WET_MS = 20;
  localparam int WET_CYC = WET_MS * 1000 * CLK_MHZ;
  localparam int RESTART_US = 200;
  localparam int RESTART_CYC = RESTART_US * CLK_MHZ;

  // Control word field positions
  localparam int CMD_WET_CONT = 15;
  localparam int CMD_SC_HI = 14;
  localparam int CMD_SC_LO = 12;
  localparam int CMD_WET_EN = 11;
  localparam int CMD_LOW_WET = 10;
  localparam int CMD_UP_BATT = 9;
  localparam int CMD_MID_BATT = 8;
  localparam int CMD_MASK_HI = 7;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // Status word layout
  localparam int STAT_SW_LO = 8;
  localparam int STAT_OVERHEAT = 7;

  // Scan period codes
  localparam logic [2:0] SC_CONT_NOHYST = 3'h6;
  localparam logic [2:0] SC_CONT = 3'h7;

  // Operating modes
  typedef enum logic [1:0] {
    ST_SHUT = 2'b00,
    ST_BOOT = 2'b01,
    ST_SCAN = 2'b10,
    ST_NORM = 2'b11
  } mode_t;

endpackage

// [rtl/spi_link.sv]
// Serial shifter running on the host's serial clock.
// Assumes the host clocks 16 bits per frame and stops the clock while
// chip select is high, so both words are quiet across the frame edges.
`timescale 1ns/1ps
`default_nettype none
module spi_link (
  // Link pins
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  // System side words
  input wire logic [15:0] tx_word,
  output logic [15:0] rx_word
);

  logic [4:0] tx_cnt_r;

  // Input bits caught on the falling edge, most significant first
  always_ff @(negedge spi_clk) begin
    if (!cs_n) begin
      rx_word <= {rx_word[14:0], sdi};
    end
  end

  // Output bits move on the rising edge; frame end clears the count
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      tx_cnt_r <= 5'h00;
      sdo <= 1'b0;
    end else begin
      // Status snapshot is frozen by the system side while low
      sdo <= tx_cnt_r[4] ? 1'b0 : tx_word[4'hF - tx_cnt_r[3:0]];
      tx_cnt_r <= tx_cnt_r[4] ? tx_cnt_r : tx_cnt_r + 5'h01;
    end
  end

endmodule
`default_nettype wire

// [rtl/contact_monitor.sv]
// Control logic of an eight-input contact monitor with wetting control.
// Assumes comparator outputs, shutdown and overheat arrive asynchronously;
// the serial link runs on its own clock and is joined by chip select.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Continuous mode: wetting on every enabled closed switch
// - Pulse mode: wetting 20ms after debounced closure
// - Wetting modes apply only to enabled inputs
// - Scan mode: wetting only in poll windows
// - Scan code selects period or continuous
// - Periodic scan: sense resistors only in window
// - Continuous codes keep sense resistors connected
// - Code 110 selects fixed hysteresis
// - Global wetting enable gates all wetting
// - Low pair wetting needs both enables; sense needs low enable only
// - Pass-through outputs mirror inputs in normal
// - Pass-through inputs leave status bits alone
// - Pass-through inputs raise no interrupt
// - Pair select bits choose battery reference
// - Mask bit one disables input interrupt
// - Enabled input change asserts interrupt
// - Mode follows scan code and shutdown
// - Power-up enters scan mode, 64ms period
// - Shutdown clears control word, stops monitoring
// - Restart after 200us, word zero, scan
// - Chip select fall releases interrupt
// - Sixteen bits; rising select loads word
// - Status high byte reports switch closure
// - One shared wetting timer, restarted
module contact_monitor #(
  parameter logic [23:0] POLL_CYC = 24'(contact_mon_pkg::POLL_CYC),
  parameter logic [23:0] SCAN_MIN_CYC = 24'(contact_mon_pkg::SCAN_MIN_CYC),
  parameter logic [23:0] WET_CYC = 24'(contact_mon_pkg::WET_CYC),
  parameter logic [23:0] RESTART_CYC = 24'(contact_mon_pkg::RESTART_CYC)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial link
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Chip pins and analog status
  input wire logic shutdown_n,
  input wire logic overheat_flag,
  input wire logic [7:0] switch_raw,
  // Interrupt, open drain
  output logic irq_o,
  output logic irq_oe,
  // Pass-through outputs
  output logic passthrough_out_a,
  output logic passthrough_out_b,
  output logic passthrough_oe,
  // Analog front-end controls
  output logic [7:0] sense_connect,
  output logic [7:0] wetting_drive,
  output logic hyst_fixed,
  output logic upper_pair_battery_sel,
  output logic middle_pair_battery_sel
);

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic sd_s1;
    logic sd_s2;
    logic ot_s1;
    logic ot_s2;
    logic [7:0] sw_s1;
    logic [7:0] sw_s2;
    contact_mon_pkg::mode_t mode;
    logic [15:0] cmd;
    logic [23:0] tmr;
    logic [23:0] wet_tmr;
    logic [7:0] smp;
    logic [7:0] deb;
    logic irq;
    logic irq_lvl;
    logic [15:0] snap;
    logic [7:0] sense;
    logic [7:0] wet;
    logic hyst_fix;
    logic pa;
    logic pb;
    logic pt_oe;
    logic sdo_oe;
  } state_t;

  state_t r;
  state_t n;
  logic [15:0] rx_word;
  logic cs_rise;
  logic cs_fall;
  logic active;
  logic tick;
  logic pass;
  logic irq_set;
  logic n_act;
  logic n_win;
  logic [23:0] per;
  logic [7:0] closed;
  logic [7:0] frozen;
  logic [7:0] stable;
  logic [7:0] new_deb;
  logic [7:0] chg;
  logic [7:0] wet_en;

  // Both continuous codes share the top two bits set
  function automatic logic is_cont(input logic [15:0] cmd);
    return cmd[contact_mon_pkg::CMD_SC_HI] & cmd[contact_mon_pkg::CMD_SC_HI - 1];
  endfunction

  // Scan period in cycles; continuous codes sample every window
  function automatic logic [23:0] period_of(input logic [2:0] sc);
    case (sc)
      3'h0: return SCAN_MIN_CYC << 5;
      3'h1: return SCAN_MIN_CYC << 4;
      3'h2: return SCAN_MIN_CYC << 3;
      3'h3: return SCAN_MIN_CYC << 2;
      3'h4: return SCAN_MIN_CYC << 1;
      3'h5: return SCAN_MIN_CYC;
      default: return POLL_CYC;
    endcase
  endfunction

  // Link shifter on the host clock
  spi_link u_link (
    .spi_clk(spi_clk),
    .cs_n(cs_n),
    .sdi(sdi),
    .sdo(sdo),
    .tx_word(r.snap),
    .rx_word(rx_word)
  );

  // Next-state logic for the whole block
  always_comb begin
    n = r;
    n.cs_s1 = cs_n;
    n.cs_s2 = r.cs_s1;
    n.cs_s3 = r.cs_s2;
    n.sd_s1 = shutdown_n;
    n.sd_s2 = r.sd_s1;
    n.ot_s1 = overheat_flag;
    n.ot_s2 = r.ot_s1;
    n.sw_s1 = switch_raw;
    n.sw_s2 = r.sw_s1;
    cs_rise = r.cs_s2 & ~r.cs_s3;
    cs_fall = ~r.cs_s2 & r.cs_s3;
    active = (r.mode == contact_mon_pkg::ST_SCAN) | (r.mode == contact_mon_pkg::ST_NORM);
    per = is_cont(r.cmd) ? POLL_CYC : period_of(r.cmd[14:12]);
    tick = active & (r.tmr == POLL_CYC - 24'h000001);
    // Ground switches pull low, battery switches pull high
    closed = r.sw_s2 ^ ~{{2{r.cmd[contact_mon_pkg::CMD_UP_BATT]}},
                         {2{r.cmd[contact_mon_pkg::CMD_MID_BATT]}}, 4'h0};
    pass = (r.mode == contact_mon_pkg::ST_NORM) & ~r.cmd[contact_mon_pkg::CMD_LOW_WET];
    frozen = pass ? 8'h03 : 8'h00;
    // Two agreeing samples in a row make a debounced state
    stable = ~(closed ^ r.smp) & ~frozen;
    new_deb = (r.deb & ~stable) | (closed & stable);
    chg = tick ? (new_deb ^ r.deb) : 8'h00;
    // Frozen pair never changes, so it cannot interrupt
    irq_set = |(chg & ~r.cmd[contact_mon_pkg::CMD_MASK_HI:0]);
    if (tick) begin
      n.smp = closed;
      n.deb = new_deb;
    end
    // One timer for all inputs, rearmed by any valid change
    if (|chg) begin
      n.wet_tmr = WET_CYC;
    end else if (r.wet_tmr != 24'h000000) begin
      n.wet_tmr = r.wet_tmr - 24'h000001;
    end
    // Set wins over the select-fall clear
    n.irq = irq_set | (r.irq & ~cs_fall);
    case (r.mode)
      contact_mon_pkg::ST_SHUT: begin
        n.cmd = contact_mon_pkg::CMD_RESET;
        n.tmr = 24'h000000;
        n.smp = 8'h00;
        n.deb = 8'h00;
        n.wet_tmr = 24'h000000;
        n.irq = 1'b0;
        if (r.sd_s2) begin
          n.mode = contact_mon_pkg::ST_BOOT;
        end
      end
      contact_mon_pkg::ST_BOOT: begin
        if (!r.sd_s2) begin
          n.mode = contact_mon_pkg::ST_SHUT;
          n.tmr = 24'h000000;
        end else if (r.tmr == RESTART_CYC - 24'h000001) begin
          // Default word gives scan mode at the longest period
          n.tmr = 24'h000000;
          n.cmd = contact_mon_pkg::CMD_RESET;
          n.mode = contact_mon_pkg::ST_SCAN;
        end else begin
          n.tmr = r.tmr + 24'h000001;
        end
      end
      contact_mon_pkg::ST_SCAN, contact_mon_pkg::ST_NORM: begin
        if (!r.sd_s2) begin
          n.mode = contact_mon_pkg::ST_SHUT;
          n.cmd = contact_mon_pkg::CMD_RESET;
          n.tmr = 24'h000000;
        end else begin
          // A shorter new period wraps at once instead of overrunning
          n.tmr = (r.tmr >= per - 24'h000001) ? 24'h000000 : r.tmr + 24'h000001;
          if (cs_rise) begin
            n.cmd = rx_word;
          end
          n.mode = is_cont(n.cmd) ? contact_mon_pkg::ST_NORM : contact_mon_pkg::ST_SCAN;
        end
      end
      default: begin
        n.mode = contact_mon_pkg::ST_SHUT;
      end
    endcase
    // Front-end controls follow the next state directly
    n_act = (n.mode == contact_mon_pkg::ST_SCAN) | (n.mode == contact_mon_pkg::ST_NORM);
    n_win = (n.mode == contact_mon_pkg::ST_NORM) | (n.tmr < POLL_CYC);
    wet_en = {{6{n.cmd[contact_mon_pkg::CMD_WET_EN]}},
              {2{n.cmd[contact_mon_pkg::CMD_WET_EN] & n.cmd[contact_mon_pkg::CMD_LOW_WET]}}};
    n.sense = (n_act & n_win) ? {6'h3F, {2{n.cmd[contact_mon_pkg::CMD_LOW_WET]}}} : 8'h00;
    n.wet = (n_act & n_win)
          ? n.deb & wet_en & (n.cmd[contact_mon_pkg::CMD_WET_CONT] ? 8'hFF
                              : {8{n.wet_tmr != 24'h000000}})
          : 8'h00;
    n.hyst_fix = n_act & (n.cmd[14:12] == contact_mon_pkg::SC_CONT_NOHYST);
    n.pt_oe = (n.mode == contact_mon_pkg::ST_NORM) & ~n.cmd[contact_mon_pkg::CMD_LOW_WET];
    n.pa = r.sw_s2[0];
    n.pb = r.sw_s2[1];
    n.sdo_oe = ~r.cs_s2;
    n.irq_lvl = 1'b0;
    // Snapshot frozen while select is low, as the link reads it then
    if (r.cs_s2) begin
      n.snap = {r.deb, r.ot_s2, 7'h00};
    end
  end

  // State register; select idles high to avoid a false edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.cs_s1 <= 1'b1;
      r.cs_s2 <= 1'b1;
      r.cs_s3 <= 1'b1;
      r.cmd <= contact_mon_pkg::CMD_RESET;
      r.mode <= contact_mon_pkg::ST_SHUT;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign sdo_oe = r.sdo_oe;
  assign irq_o = r.irq_lvl;
  assign irq_oe = r.irq;
  assign passthrough_out_a = r.pa;
  assign passthrough_out_b = r.pb;
  assign passthrough_oe = r.pt_oe;
  assign sense_connect = r.sense;
  assign wetting_drive = r.wet;
  assign hyst_fixed = r.hyst_fix;
  assign upper_pair_battery_sel = r.cmd[contact_mon_pkg::CMD_UP_BATT];
  assign middle_pair_battery_sel = r.cmd[contact_mon_pkg::CMD_MID_BATT];

  // Checks on the block's own behaviour
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_shut_clears_word: assert property (
    (r.mode != contact_mon_pkg::ST_SHUT && !r.sd_s2)
    |=> (r.mode == contact_mon_pkg::ST_SHUT && r.cmd == 16'h0000 && r.sense == 8'h00)
  ) else $error("shutdown did not clear the block");

  a_boot_to_scan: assert property (
    (r.mode == contact_mon_pkg::ST_BOOT && r.sd_s2 && r.tmr == RESTART_CYC - 24'h000001)
    |=> (r.mode == contact_mon_pkg::ST_SCAN && r.cmd == 16'h0000)
  ) else $error("restart did not end in scan mode");

  a_global_wet_off: assert property (
    !r.cmd[contact_mon_pkg::CMD_WET_EN] |-> r.wet == 8'h00
  ) else $error("wetting with global enable clear");

  a_low_pair_off: assert property (
    !r.cmd[contact_mon_pkg::CMD_LOW_WET] |-> (r.wet[1:0] == 2'b00 && r.sense[1:0] == 2'b00)
  ) else $error("low pair active while disabled");

  a_scan_gap_quiet: assert property (
    (r.mode == contact_mon_pkg::ST_SCAN && r.tmr >= POLL_CYC)
    |-> (r.sense == 8'h00 && r.wet == 8'h00)
  ) else $error("front end active between polls");

  a_norm_sense_on: assert property (
    r.mode == contact_mon_pkg::ST_NORM |-> r.sense[7:2] == 6'h3F
  ) else $error("sense dropped in normal mode");

  a_pulse_ends: assert property (
    (!r.cmd[contact_mon_pkg::CMD_WET_CONT] && r.wet_tmr == 24'h000000) |-> r.wet == 8'h00
  ) else $error("wetting pulse outlived its timer");

  a_cont_wet_on: assert property (
    (r.mode == contact_mon_pkg::ST_NORM && r.cmd[contact_mon_pkg::CMD_WET_CONT]
     && r.cmd[contact_mon_pkg::CMD_WET_EN]) |-> r.wet[7:2] == r.deb[7:2]
  ) else $error("continuous wetting missing");

  a_irq_release: assert property (
    (cs_fall && !irq_set) |=> !r.irq
  ) else $error("interrupt not released on select fall");

  a_pass_enable: assert property (
    $rose(r.pt_oe) |-> $past(r.mode) == contact_mon_pkg::ST_NORM || r.mode == contact_mon_pkg::ST_NORM
  ) else $error("pass-through driven outside normal mode");

  a_hyst_code: assert property (
    $changed(r.cmd) && r.cmd[14:12] == contact_mon_pkg::SC_CONT_NOHYST
    && r.mode == contact_mon_pkg::ST_NORM |-> r.hyst_fix
  ) else $error("fixed hysteresis not selected");

  c_irq_raised: cover property ($rose(r.irq));
  c_word_loaded: cover property (cs_rise && r.mode == contact_mon_pkg::ST_SCAN);
  c_scan_to_norm: cover property (r.mode == contact_mon_pkg::ST_SCAN ##1 r.mode == contact_mon_pkg::ST_NORM);
  c_wet_pulse: cover property ($rose(r.wet != 8'h00));

endmodule
`default_nettype wire

// [verif/host_model.sv]
// Behavioural serial master that writes the control word and reads status.
// Assumes a 30 ns serial clock that only runs inside frames.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Serial pins
  output logic spi_clk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // One frame of 16 bits, msb first; clock idles low between frames
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    #53; // Lets the status snapshot freeze first
    for (int i = 15; i >= 0; i--) begin
      spi_clk = 1'b1;
      sdi = tx[i];
      #15;
      rx[i] = sdo_oe ? sdo : 1'bx; // Undriven line never passes for data
      spi_clk = 1'b0;
      #15;
    end
    cs_n = 1'b1;
    sdi = ~tx[0]; // Released line shows no stale value
    #100; // Select stays high well over five system cycles
  endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the contact monitor control logic.
// Assumes shortened timing parameters and the host model on the link.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  typedef struct {logic [15:0] w; logic [7:0] sense; logic hy; logic up; logic mid; logic poe;} row_t;
  logic sys_clk = 1'b0, rst_n = 1'b0, shutdown_n = 1'b1, overheat_flag = 1'b0;
  logic [7:0] switch_raw = 8'hFF;
  logic spi_clk, cs_n, sdi, sdo, sdo_oe, irq_o, irq_oe, pa, pb, poe, hyst, upsel, midsel;
  logic [7:0] sense_connect, wetting_drive;
  logic [15:0] rx;
  int miscompares = 0, checked = 0, cycles = 0;
  // Four-state counters so an unknown output cannot pass as zero
  integer s, w;
  row_t rows [4] = '{'{16'h7000, 8'hFC, 1'b0, 1'b0, 1'b0, 1'b1}, '{16'h6400, 8'hFF, 1'b1, 1'b0, 1'b0, 1'b0},
                     '{16'h7500, 8'hFF, 1'b0, 1'b0, 1'b1, 1'b0}, '{16'h6200, 8'hFC, 1'b1, 1'b1, 1'b0, 1'b1}};

  always #5 sys_clk = ~sys_clk;

  contact_monitor #(.POLL_CYC(24'h000014), .SCAN_MIN_CYC(24'h000064), .WET_CYC(24'h00012C),
    .RESTART_CYC(24'h00001E)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .spi_clk(spi_clk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .shutdown_n(shutdown_n), .overheat_flag(overheat_flag), .switch_raw(switch_raw),
    .irq_o(irq_o), .irq_oe(irq_oe), .passthrough_out_a(pa), .passthrough_out_b(pb),
    .passthrough_oe(poe), .sense_connect(sense_connect), .wetting_drive(wetting_drive),
    .hyst_fixed(hyst), .upper_pair_battery_sel(upsel), .middle_pair_battery_sel(midsel));

  host_model i_host (.spi_clk(spi_clk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

  // Closing report, reached from the main sequence or the hang guard
  task automatic wrap_up();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Inputs change just after the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Writes a word, then waits out the crossing into the system domain
  task automatic put(input logic [15:0] wd);
    i_host.xfer(wd, rx);
    cyc(10);
  endtask

  // Counts window cycles of sense on input 7 and wetting on input 3
  task automatic count_on(input int n);
    s = 0;
    w = 0;
    repeat (n) begin
      cyc(1);
      s += sense_connect[7];
      w += wetting_drive[3];
    end
  endtask

  // Hang guard sized well past the whole sequence
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    cyc(4);
    `CHK(sense_connect, 8'h00)
    rst_n = 1'b1;
    cyc(60);
    // Normal mode decode of the control word
    foreach (rows[i]) begin
      put(rows[i].w);
      `CHK(sense_connect, rows[i].sense)
      `CHK(hyst, rows[i].hy)
      `CHK(upsel, rows[i].up)
      `CHK(midsel, rows[i].mid)
      `CHK(poe, rows[i].poe)
      `CHK(sdo_oe, 1'b0)
    end
    // Status and interrupt: inputs 7 and 6 battery, others ground
    switch_raw = 8'h7F;
    overheat_flag = 1'b1;
    put(16'h7600);
    cyc(80);
    put(16'h7600);
    `CHK(irq_oe, 1'b0)
    switch_raw = 8'h77;
    cyc(80);
    `CHK(irq_oe, 1'b1)
    `CHK(irq_o, 1'b0)
    i_host.xfer(16'h7600, rx);
    `CHK(rx, 16'h4880)
    cyc(5);
    `CHK(irq_oe, 1'b0)
    // Masked input still updates status but stays quiet
    put(16'h7608);
    switch_raw = 8'h7F;
    cyc(80);
    `CHK(irq_oe, 1'b0)
    i_host.xfer(16'h7608, rx);
    `CHK(rx, 16'h4080)
    // Pass-through on input 0: mirrored, not reported, no interrupt
    put(16'h7200);
    switch_raw = 8'h7E;
    cyc(80);
    `CHK(irq_oe, 1'b0)
    `CHK(pa, 1'b0)
    `CHK(pb, 1'b1)
    i_host.xfer(16'h7200, rx);
    `CHK(rx, 16'h4080)
    // Continuous wetting, then global disable
    put(16'hFC00);
    switch_raw = 8'hF7;
    cyc(80);
    `CHK(wetting_drive, 8'h08)
    put(16'h7400);
    `CHK(wetting_drive, 8'h00)
    // Pulse wetting: one shared timer covers both closed switches
    put(16'h7C00);
    switch_raw = 8'hD7;
    cyc(80);
    `CHK(wetting_drive, 8'h28)
    cyc(300);
    `CHK(wetting_drive, 8'h00)
    // Scan code 5: four periods of 100 hold 80 window cycles
    put(16'hD800);
    `CHK(poe, 1'b0)
    count_on(400);
    `CHK(s, 80)
    `CHK(w, 80)
    // Shutdown, restart into scan with the longest period
    shutdown_n = 1'b0;
    cyc(5);
    `CHK(sense_connect, 8'h00)
    `CHK(wetting_drive, 8'h00)
    shutdown_n = 1'b1;
    cyc(40);
    count_on(3200);
    `CHK(s, 20)
    `CHK(w, 0)
    wrap_up();
  end
endmodule
`default_nettype wire
